// ---- common/rtp_defines.svh ----
/*
  Offsets, field positions, reset values, command codes and timing counts
  for the reset sequencer and test port enable block.
  Assumes a 250 MHz device clock; included by bare name.
*/
`ifndef RTP_DEFINES_SVH
`define RTP_DEFINES_SVH

// Register offsets from the I/O register base
`define RTP_OFF_TEST_EN 8'hC7
`define RTP_OFF_PMA 8'hB0
`define RTP_OFF_PMB 8'hB4
`define RTP_OFF_VM 8'hB8

// Field positions
`define RTP_PMA_ARRAY_CLK 4
`define RTP_PMA_MCELL_CLK 5
`define RTP_PMB_CTL0 2
`define RTP_PMB_DBE 6
`define RTP_TEST_EN_BIT 0
`define RTP_VM_SRAM_CODE 0
`define RTP_VM_PERIPH 1

// Writable bits and reset values
`define RTP_PMA_WMASK 8'h3A
`define RTP_PMB_WMASK 8'h7C
`define RTP_TEST_WMASK 8'h01
`define RTP_VM_WMASK 8'h1F
`define RTP_VM_CLRMASK 8'hFC
`define RTP_REG_RST 8'h00

// Serial test commands
`define RTP_CMD_ENABLE 8'h15
`define RTP_CMD_ENABLE_EXT 8'h19
`define RTP_CMD_ENABLE_OD 8'h1A
`define RTP_CMD_DISABLE 8'h16
`define RTP_CMD_CLEAR 8'h17

// Times in ns and derived counts
`define RTP_CLK_NS 4
`define RTP_POR_PULSE_NS 1000
`define RTP_WARM_PULSE_NS 200
`define RTP_RECOVERY_NS 480
`define RTP_ABORT_NS 100
`define RTP_POR_CYC ((`RTP_POR_PULSE_NS + `RTP_CLK_NS - 1) / `RTP_CLK_NS)
`define RTP_WARM_CYC ((`RTP_WARM_PULSE_NS + `RTP_CLK_NS - 1) / `RTP_CLK_NS)
`define RTP_REC_CYC ((`RTP_RECOVERY_NS + `RTP_CLK_NS - 1) / `RTP_CLK_NS)
`define RTP_ABORT_CYC (`RTP_ABORT_NS / `RTP_CLK_NS)
`define RTP_PROG_CYC 16
`define RTP_ERASE_CYC 64

`endif

// ---- common/rtp_pkg.sv ----
/*
  Types shared by the reset sequencer and test port enable block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package rtp_pkg;

  typedef struct packed {
    logic dbe;
    logic ale;
    logic c2;
    logic c1;
    logic c0;
  } rtp_ctl_t;

  typedef enum logic [1:0] {RS_HOLD, RS_RECOVER, RS_RUN} rtp_rst_state_t;
  typedef enum logic [1:0] {FL_READ, FL_PROGRAM, FL_ERASE} rtp_flash_state_t;
  typedef enum logic {TP_OFF, TP_ON} rtp_tp_state_t;

  function automatic logic rtp_rise(input logic prev, input logic cur);
    return cur & ~prev;
  endfunction

endpackage

// ---- design/rtp_reset_seq.sv ----
/*
  Reset pin qualification: power-on and warm pulse widths, recovery period.
  Assumes the reset pin level arrives already synchronised to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module rtp_reset_seq #(
  parameter int POR_CYC = 250,
  parameter int WARM_CYC = 50,
  parameter int REC_CYC = 120,
  parameter int CW = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic pin_low_s,
  output logic dev_reset_o,
  output logic por_active_o,
  output logic cfg_loaded_o
);
  rtp_pkg::rtp_rst_state_t state_reg;
  logic [CW-1:0] cnt_reg;
  logic por_reg;
  logic cfg_reg;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= rtp_pkg::RS_HOLD;
      cnt_reg <= '0;
      por_reg <= 1'b1;
      cfg_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        rtp_pkg::RS_HOLD: begin
          if (pin_low_s) begin
            if (cnt_reg != '1)
              cnt_reg <= cnt_reg + 1'b1;
            if (por_reg && cnt_reg >= CW'(POR_CYC - 1))
              cfg_reg <= 1'b1; // RULE4
          end else if (!por_reg || cfg_reg) begin
            state_reg <= rtp_pkg::RS_RECOVER; // RULE25
            cnt_reg <= '0;
            por_reg <= 1'b0;
          end else begin
            cnt_reg <= '0;
          end
        end
        rtp_pkg::RS_RECOVER: begin
          if (pin_low_s) begin
            state_reg <= rtp_pkg::RS_HOLD;
            cnt_reg <= '0;
          end else if (cnt_reg == CW'(REC_CYC - 1)) begin
            state_reg <= rtp_pkg::RS_RUN; // RULE5
            cnt_reg <= '0;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        rtp_pkg::RS_RUN: begin
          if (!pin_low_s) begin
            cnt_reg <= '0;
          end else if (cnt_reg == CW'(WARM_CYC - 1)) begin
            state_reg <= rtp_pkg::RS_HOLD; // RULE9
            cnt_reg <= '0;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
      endcase
    end
  end

  assign dev_reset_o = (state_reg != rtp_pkg::RS_RUN);
  assign por_active_o = por_reg;
  assign cfg_loaded_o = cfg_reg;

  AST_RECOVERY_LEN: assert property (@(posedge clk) disable iff (sys_rst) // RULE5
    $fell(dev_reset_o) |-> $past(cnt_reg) == CW'(REC_CYC - 1))
    else $error("recovery period length wrong");

  AST_CFG_NEEDS_LOW: assert property (@(posedge clk) disable iff (sys_rst) // RULE4
    $rose(cfg_loaded_o) |-> $past(pin_low_s) && $past(por_reg))
    else $error("configuration loaded without reset pulse");

endmodule // rtp_reset_seq
`default_nettype wire

// ---- design/rtp_test_port.sv ----
/*
  Serial test command receiver: enables the data output and extensions.
  Assumes test clock edges and pin levels come synchronised to clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rtp_defines.svh"
module rtp_test_port (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic port_rst,
  input wire logic tck_rise,
  input wire logic tck_fall,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo_o,
  output logic tdo_en_o,
  output logic ext_en_o,
  output logic od_o,
  output logic clear_err_o
);
  rtp_pkg::rtp_tp_state_t state_reg;
  logic [7:0] shift_reg;
  logic [7:0] cmd_next;
  logic ext_reg;
  logic od_reg;
  logic clr_reg;
  logic tdo_reg;

  assign cmd_next = {tdi, shift_reg[7:1]};

  // Command byte ends on the test clock edge that sees mode select high
  always_ff @(posedge clk) begin
    if (sys_rst || port_rst) begin
      state_reg <= rtp_pkg::TP_OFF; // RULE19
      shift_reg <= 8'h00;
      ext_reg <= 1'b0;
      od_reg <= 1'b0;
      clr_reg <= 1'b0;
    end else begin
      clr_reg <= 1'b0;
      if (tck_rise) begin
        shift_reg <= cmd_next;
        if (tms) begin
          unique case (cmd_next) // RULE21
            `RTP_CMD_ENABLE: state_reg <= rtp_pkg::TP_ON; // RULE17
            `RTP_CMD_ENABLE_EXT: begin
              state_reg <= rtp_pkg::TP_ON;
              ext_reg <= 1'b1;
            end
            `RTP_CMD_ENABLE_OD: begin
              state_reg <= rtp_pkg::TP_ON;
              ext_reg <= 1'b1;
              od_reg <= 1'b1;
            end
            `RTP_CMD_DISABLE: begin
              state_reg <= rtp_pkg::TP_OFF;
              ext_reg <= 1'b0;
              od_reg <= 1'b0;
            end
            `RTP_CMD_CLEAR: clr_reg <= 1'b1;
            default: ;
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst)
      tdo_reg <= 1'b0;
    else if (tck_fall)
      tdo_reg <= shift_reg[0];
  end

  assign tdo_o = tdo_reg;
  assign tdo_en_o = (state_reg == rtp_pkg::TP_ON);
  assign ext_en_o = ext_reg & tdo_en_o;
  assign od_o = od_reg;
  assign clear_err_o = clr_reg;

  AST_PORT_RST_OFF: assert property (@(posedge clk) disable iff (sys_rst) // RULE19
    port_rst |=> !tdo_en_o && !ext_en_o)
    else $error("test channel survived a blocking reset");

  AST_ENABLE_CMD: assert property (@(posedge clk) disable iff (sys_rst) // RULE17
    $rose(tdo_en_o) |-> $past(tck_rise) && $past(tms))
    else $error("data output enabled without command");

endmodule // rtp_test_port
`default_nettype wire

// ---- design/rtp_top.sv ----
/*
  Reset sequencing, logic clock and control gating, pin states in reset,
  flash cycle control and the test pin hand-over on port C.
  Assumes a host register port on pins, a test clock of about 8 MHz and
  logic-array and macrocell signals on clk.
*/
// Summary of operation
// [RULE1] Bits 4/5 cut logic clock from array/macrocells
// [RULE2] Bits 2-6 cut control inputs from array
// [RULE3] Software should gate unused inputs to save power
// [RULE4] Power-on pulse loads configuration and clears registers
// [RULE5] Recovery period follows reset release before access
// [RULE6] Flash controller starts in read mode
// [RULE7] Sector selects low, write strobe high in reset; code drives only the sector selects and has no write strobe output
// [RULE8] Supply lockout blocks flash write start
// [RULE9] Warm reset needs shorter pulse, same recovery
// [RULE10] Logic outputs valid in warm reset, after load
// [RULE11] Reset aborts flash cycle within abort width
// [RULE12] Pin direction states in resets and power-down
// [RULE13] Power-on clears gating registers and macrocells
// [RULE14] Map register reloads; two bits always cleared
// [RULE15] Test pins active is OR of three sources
// [RULE16] Inactive: general I/O; active: test interface
// [RULE17] Pins inputs until enabling command drives output
// [RULE18] Enable register at C7h, cleared by reset
// [RULE19] Reset blocks test port unless dedicated; code also exempts a blank device
// [RULE20] Blank device enables test pins by default
// [RULE21] Configuration commands only; select follows cable
// [RULE22] Port C pin assignment of test signals
// [RULE23] Bit 0 enables; other bits write zero
// [RULE24] Reset times are parameterised cycle counts
// [RULE25] Reset pin synchronised; release starts recovery
`timescale 1ns/1ps
`default_nettype none
`include "rtp_defines.svh"
module rtp_top #(
  parameter int MC_W = 8,
  parameter logic NVM_TEST_DEDICATED = 1'b0,
  parameter logic DEVICE_BLANK = 1'b1,
  parameter logic [7:0] VM_CONFIG = 8'h1F,
  parameter int POR_CYC = `RTP_POR_CYC, // RULE24
  parameter int WARM_CYC = `RTP_WARM_CYC,
  parameter int REC_CYC = `RTP_REC_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic reset_pin_n,
  input wire logic lockout_pin,
  input wire logic mcu_cs_n,
  input wire logic mcu_wr_n,
  input wire logic mcu_rd_n,
  input wire logic [7:0] mcu_addr,
  input wire logic [7:0] mcu_data_in,
  output logic [7:0] mcu_data_out,
  output logic mcu_data_oe,
  input wire logic pld_clock_input,
  input wire rtp_pkg::rtp_ctl_t ctl_pins,
  output rtp_pkg::rtp_ctl_t array_ctl,
  output logic pld_array_clk,
  input wire logic [MC_W-1:0] mc_d,
  input wire logic [MC_W-1:0] mc_reset_eq,
  input wire logic [MC_W-1:0] mc_preset_eq,
  output logic [MC_W-1:0] mc_q,
  output logic pld_out_valid,
  input wire logic power_down,
  input wire logic test_pin_select_term,
  input wire logic flash_prog_start,
  input wire logic flash_erase_start,
  output logic flash_ready,
  output logic [7:0] sector_select_en,
  input wire logic [7:0] io_oe_req,
  output logic [7:0] io_oe,
  input wire logic [7:0] addr_oe_req,
  output logic [7:0] addr_oe,
  input wire logic [7:0] data_port_oe_req,
  output logic [7:0] data_port_oe,
  input wire logic [7:0] periph_oe_req,
  output logic [7:0] periph_oe,
  output logic [7:0] memory_map_config,
  input wire logic [7:0] pc_in,
  output logic [7:0] pc_out,
  output logic [7:0] pc_oe,
  input wire logic [7:0] gpio_out,
  input wire logic [7:0] gpio_oe,
  output logic test_pins_active
);
  localparam int ABT = `RTP_ABORT_CYC;

  // Two-flop synchronisers for every pin that reaches logic
  localparam int SW = 35;
  logic [SW-1:0] pin_raw;
  logic [SW-1:0] sync1_reg;
  logic [SW-1:0] sync2_reg;
  assign pin_raw = {~reset_pin_n, lockout_pin, mcu_cs_n, mcu_wr_n,
                    mcu_rd_n, mcu_addr, mcu_data_in, pld_clock_input,
                    ctl_pins, pc_in};
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync1_reg <= {5'h07, 8'h00, 8'h00, 1'b0, 5'h00, 8'h00} | {2'b0, 3'b111, 30'h0};
      sync2_reg <= {2'b0, 3'b111, 30'h0};
    end else begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
    end
  end

  logic pin_low_s;
  logic lockout_s;
  logic cs_n_s;
  logic wr_n_s;
  logic rd_n_s;
  logic [7:0] addr_s;
  logic [7:0] wdata_s;
  logic pclk_s;
  rtp_pkg::rtp_ctl_t ctl_s;
  logic [7:0] pc_s;
  assign {pin_low_s, lockout_s, cs_n_s, wr_n_s, rd_n_s, addr_s, wdata_s,
          pclk_s, ctl_s, pc_s} = sync2_reg;

  // Edge history for the two sampled clocks and the write strobe
  logic pclk_d_reg;
  logic tck_d_reg;
  logic wr_n_d_reg;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pclk_d_reg <= 1'b0;
      tck_d_reg <= 1'b0;
      wr_n_d_reg <= 1'b1;
    end else begin
      pclk_d_reg <= pclk_s;
      tck_d_reg <= pc_s[1];
      wr_n_d_reg <= wr_n_s;
    end
  end

  logic dev_reset;
  logic por_active;
  logic cfg_loaded;
  rtp_reset_seq #(
    .POR_CYC(POR_CYC),
    .WARM_CYC(WARM_CYC),
    .REC_CYC(REC_CYC),
    .CW(16)
  ) u_seq (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin_low_s(pin_low_s),
    .dev_reset_o(dev_reset),
    .por_active_o(por_active),
    .cfg_loaded_o(cfg_loaded)
  );

  // Register file; accesses during reset are ignored
  logic [7:0] pma_reg;
  logic [7:0] pmb_reg;
  logic [7:0] test_en_reg;
  logic [7:0] vm_reg;
  logic wr_take;
  assign wr_take = ~cs_n_s & rtp_pkg::rtp_rise(wr_n_s, wr_n_d_reg)
                   & ~dev_reset;

  always_ff @(posedge clk) begin
    if (sys_rst || por_active) begin
      pma_reg <= `RTP_REG_RST; // RULE13
      pmb_reg <= `RTP_REG_RST;
    end else if (wr_take && addr_s == `RTP_OFF_PMA) begin
      pma_reg <= wdata_s & `RTP_PMA_WMASK; // RULE1
    end else if (wr_take && addr_s == `RTP_OFF_PMB) begin
      pmb_reg <= wdata_s & `RTP_PMB_WMASK; // RULE2
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || dev_reset)
      test_en_reg <= `RTP_REG_RST; // RULE18
    else if (wr_take && addr_s == `RTP_OFF_TEST_EN)
      test_en_reg <= wdata_s & `RTP_TEST_WMASK; // RULE23
  end

  always_ff @(posedge clk) begin
    if (sys_rst)
      vm_reg <= `RTP_REG_RST;
    else if (dev_reset)
      vm_reg <= VM_CONFIG & `RTP_VM_CLRMASK; // RULE14
    else if (wr_take && addr_s == `RTP_OFF_VM)
      vm_reg <= wdata_s & `RTP_VM_WMASK;
  end
  assign memory_map_config = vm_reg;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mcu_data_out <= 8'h00;
    end else begin
      unique case (addr_s)
        `RTP_OFF_PMA: mcu_data_out <= pma_reg;
        `RTP_OFF_PMB: mcu_data_out <= pmb_reg;
        `RTP_OFF_TEST_EN: mcu_data_out <= test_en_reg;
        `RTP_OFF_VM: mcu_data_out <= vm_reg;
        default: mcu_data_out <= 8'h00;
      endcase
    end
  end
  assign mcu_data_oe = ~cs_n_s & ~rd_n_s & ~dev_reset;

  // Logic clock and control input gating toward the product-term array
  assign pld_array_clk = pclk_s & ~pma_reg[`RTP_PMA_ARRAY_CLK]; // RULE1
  assign array_ctl = ctl_s & ~rtp_pkg::rtp_ctl_t'(
    pmb_reg[`RTP_PMB_DBE:`RTP_PMB_CTL0]); // RULE2

  // Macrocells clear only on power-on; warm reset uses their equations
  logic mc_edge;
  assign mc_edge = rtp_pkg::rtp_rise(pclk_d_reg, pclk_s)
                   & ~pma_reg[`RTP_PMA_MCELL_CLK]; // RULE1
  always_ff @(posedge clk) begin
    if (sys_rst || por_active)
      mc_q <= '0; // RULE13
    else if (|(mc_reset_eq | mc_preset_eq))
      mc_q <= (mc_q & ~mc_reset_eq) | mc_preset_eq;
    else if (mc_edge)
      mc_q <= mc_d;
  end
  assign pld_out_valid = cfg_loaded; // RULE10

  // Flash cycle controller
  rtp_pkg::rtp_flash_state_t fl_state_reg;
  logic [7:0] fl_cnt_reg;
  logic err_reg;
  logic blocked_start;
  logic clear_err;
  logic tp_rst;
  logic tdo_en;
  assign blocked_start = (flash_prog_start | flash_erase_start) & lockout_s;

  always_ff @(posedge clk) begin
    if (sys_rst || pin_low_s || dev_reset) begin
      fl_state_reg <= rtp_pkg::FL_READ; // RULE6 RULE11
      fl_cnt_reg <= 8'h00;
    end else begin
      unique case (fl_state_reg)
        rtp_pkg::FL_READ: begin
          if (!lockout_s && flash_prog_start) begin // RULE8
            fl_state_reg <= rtp_pkg::FL_PROGRAM;
            fl_cnt_reg <= 8'(`RTP_PROG_CYC - 1);
          end else if (!lockout_s && flash_erase_start) begin
            fl_state_reg <= rtp_pkg::FL_ERASE;
            fl_cnt_reg <= 8'(`RTP_ERASE_CYC - 1);
          end
        end
        rtp_pkg::FL_PROGRAM, rtp_pkg::FL_ERASE: begin
          if (fl_cnt_reg == 8'h00)
            fl_state_reg <= rtp_pkg::FL_READ;
          else
            fl_cnt_reg <= fl_cnt_reg - 1'b1;
        end
        default: fl_state_reg <= rtp_pkg::FL_READ;
      endcase
    end
  end
  assign flash_ready = (fl_state_reg == rtp_pkg::FL_READ);
  assign sector_select_en = dev_reset ? 8'h00 : 8'hFF; // RULE7

  // Error flag: set wins over clear
  always_ff @(posedge clk) begin
    if (sys_rst)
      err_reg <= 1'b0;
    else if (blocked_start)
      err_reg <= 1'b1;
    else if (clear_err || (dev_reset && !tdo_en))
      err_reg <= 1'b0;
  end

  // Pin direction in reset and power-down
  always_comb begin
    io_oe = io_oe_req;
    addr_oe = addr_oe_req;
    data_port_oe = data_port_oe_req;
    periph_oe = periph_oe_req;
    if (dev_reset) begin
      io_oe = 8'h00; // RULE12
      addr_oe = 8'h00;
    end
    if (dev_reset || power_down) begin
      data_port_oe = 8'h00;
      periph_oe = 8'h00;
    end
  end

  // Test pin hand-over
  logic nvm_on;
  logic tdo;
  logic ext_en;
  logic od;
  assign nvm_on = NVM_TEST_DEDICATED | DEVICE_BLANK; // RULE20
  assign test_pins_active = nvm_on | test_en_reg[`RTP_TEST_EN_BIT]
                            | test_pin_select_term; // RULE15
  assign tp_rst = ~test_pins_active | (dev_reset & ~nvm_on); // RULE19

  rtp_test_port u_tp (
    .clk(clk),
    .sys_rst(sys_rst),
    .port_rst(tp_rst),
    .tck_rise(rtp_pkg::rtp_rise(tck_d_reg, pc_s[1])),
    .tck_fall(rtp_pkg::rtp_rise(pc_s[1], tck_d_reg)),
    .tms(pc_s[0]),
    .tdi(pc_s[5]),
    .tdo_o(tdo),
    .tdo_en_o(tdo_en),
    .ext_en_o(ext_en),
    .od_o(od),
    .clear_err_o(clear_err)
  );

  always_comb begin
    pc_out = gpio_out;
    pc_oe = gpio_oe;
    if (test_pins_active) begin // RULE16
      pc_out[6] = tdo; // RULE22
      pc_oe[6] = tdo_en; // RULE17
      pc_out[0] = 1'b0;
      pc_oe[0] = 1'b0;
      pc_out[1] = 1'b0;
      pc_oe[1] = 1'b0;
      pc_out[5] = 1'b0;
      pc_oe[5] = 1'b0;
      pc_out[3] = flash_ready;
      pc_oe[3] = ext_en & (~od | ~flash_ready);
      pc_out[4] = ~err_reg;
      pc_oe[4] = ext_en & (~od | err_reg);
    end
  end

  sequence s_abort;
    (fl_state_reg != rtp_pkg::FL_READ) && pin_low_s;
  endsequence

  AST_ABORT_TO_READ: assert property (@(posedge clk) disable iff (sys_rst) // RULE11
    s_abort |-> ##[1:ABT] flash_ready)
    else $error("flash cycle not aborted in time");

  AST_LOCKOUT: assert property (@(posedge clk) disable iff (sys_rst) // RULE8
    flash_ready && lockout_s |=> flash_ready)
    else $error("flash cycle started under lockout");

  AST_ARRAY_CLK_CUT: assert property (@(posedge clk) disable iff (sys_rst) // RULE1
    pma_reg[`RTP_PMA_ARRAY_CLK] |-> !pld_array_clk)
    else $error("array clock not cut");

  AST_CTL_CUT: assert property (@(posedge clk) disable iff (sys_rst) // RULE2
    pmb_reg[`RTP_PMB_CTL0] && pmb_reg[`RTP_PMB_DBE] |->
      !array_ctl.c0 && !array_ctl.dbe)
    else $error("control input not cut");

  AST_PINS_IN_RESET: assert property (@(posedge clk) disable iff (sys_rst) // RULE12
    dev_reset |-> io_oe == 8'h00 && addr_oe == 8'h00 && !mcu_data_oe
      && data_port_oe == 8'h00)
    else $error("pin driven during reset");

  AST_TEST_EN_CLR: assert property (@(posedge clk) disable iff (sys_rst) // RULE18
    dev_reset |=> test_en_reg == 8'h00)
    else $error("test enable survived reset");

  AST_VM_BITS: assert property (@(posedge clk) disable iff (sys_rst) // RULE14
    dev_reset |=> !vm_reg[`RTP_VM_SRAM_CODE] && !vm_reg[`RTP_VM_PERIPH])
    else $error("map register bits not cleared");

  AST_TDO_HELD: assert property (@(posedge clk) disable iff (sys_rst) // RULE17
    test_pins_active && !tdo_en |-> !pc_oe[6] && !pc_oe[0] && !pc_oe[5])
    else $error("test pin driven before command");

  AST_GPIO_MODE: assert property (@(posedge clk) disable iff (sys_rst) // RULE16
    !test_pins_active |-> pc_oe == gpio_oe && pc_out == gpio_out)
    else $error("port pins not general I/O");

  AST_PM_WARM_KEEP: assert property (@(posedge clk) disable iff (sys_rst) // RULE13
    dev_reset && !por_active && !$past(por_active) |-> $stable(pma_reg))
    else $error("gating register changed in warm reset");

endmodule // rtp_top
`default_nettype wire

// ---- testbench/rtp_test_ctl.sv ----
/*
  Serial test controller model: test clock, mode select, serial data in
  and the programming cable's enable line.
  Assumes the bench routes the lines onto port C pins 0, 1 and 5.
*/
`timescale 1ns/1ps
`default_nettype none
module rtp_test_ctl (
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic cable_en_n
);
  initial begin
    tck = 1'b0;
    tms = 1'b0;
    tdi = 1'b0;
    cable_en_n = 1'b1;
  end
  // Clock stands low between frames; 125 ns period inside them
  task automatic send(input logic [7:0] cmd);
    integer i;
    cable_en_n = 1'b0;
    for (i = 0; i < 8; i++) begin
      tdi = cmd[i];
      tms = (i == 7);
      #62.5 tck = 1'b1;
      #62.5 tck = 1'b0;
    end
    tms = 1'b0;
    tdi = ~tdi;
  endtask
  task automatic unplug();
    cable_en_n = 1'b1;
  endtask
endmodule // rtp_test_ctl
`default_nettype wire

// ---- testbench/rtp_top_test.sv ----
/*
  Self-checking bench: register tasks on the host strobes, reset pulses,
  flash cycles and serial commands.
  Assumes rtp_top with small reset counts and a non-blank device.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rtp_defines.svh"
module rtp_top_test;
  localparam int POR = 8;
  localparam int WARM = 4;
  localparam int REC = 6;
  logic clk, sys_rst, reset_pin_n, lockout_pin, mcu_cs_n, mcu_wr_n, mcu_rd_n;
  logic pld_clock_input, power_down, flash_prog_start, flash_erase_start;
  logic [7:0] mcu_addr, mcu_data_in, mc_d, io_oe_req, pc_gp, gpio_out, gpio_oe;
  logic [7:0] mcu_data_out, mc_q, sector_select_en, io_oe, addr_oe, pc_oe;
  logic [7:0] data_port_oe, periph_oe, memory_map_config, pc_out, pc_in;
  logic [7:0] mc_re, mc_pr;
  logic mcu_data_oe, pld_array_clk, pld_out_valid, flash_ready;
  logic test_pins_active;
  rtp_pkg::rtp_ctl_t ctl_pins, array_ctl;
  wire logic tck, tms, tdi, cab_n;
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;
  int i;
  assign pc_in = {pc_gp[7:6], tdi, pc_gp[4:2], tck, tms};
  rtp_test_ctl ctl (.tck, .tms, .tdi, .cable_en_n(cab_n));
  rtp_top #(.NVM_TEST_DEDICATED(1'b0), .DEVICE_BLANK(1'b0), .POR_CYC(POR),
    .WARM_CYC(WARM), .REC_CYC(REC)) DUT (
    .clk, .sys_rst, .reset_pin_n, .lockout_pin, .mcu_cs_n, .mcu_wr_n,
    .mcu_rd_n, .mcu_addr, .mcu_data_in, .mcu_data_out, .mcu_data_oe,
    .pld_clock_input, .ctl_pins, .array_ctl, .pld_array_clk, .mc_d,
    .mc_reset_eq(mc_re), .mc_preset_eq(mc_pr), .mc_q, .pld_out_valid,
    .power_down, .test_pin_select_term(~cab_n), .flash_prog_start,
    .flash_erase_start, .flash_ready, .sector_select_en, .io_oe_req, .io_oe,
    .addr_oe_req(io_oe_req), .addr_oe, .data_port_oe_req(io_oe_req),
    .data_port_oe, .periph_oe_req(io_oe_req), .periph_oe, .memory_map_config,
    .pc_in, .pc_out, .pc_oe, .gpio_out, .gpio_oe, .test_pins_active);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Hang guard; the full sequence needs well under 5000 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Strobes held four cycles each, beyond the two the synchroniser needs
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    step(1);
    mcu_addr = a;
    mcu_data_in = d;
    mcu_cs_n = 1'b0;
    mcu_wr_n = 1'b0;
    step(4);
    mcu_wr_n = 1'b1;
    step(4);
    mcu_cs_n = 1'b1;
    step(4);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    step(1);
    mcu_addr = a;
    mcu_cs_n = 1'b0;
    mcu_rd_n = 1'b0;
    step(5);
    check(mcu_data_out, exp);
    check(8'(mcu_data_oe), 8'h01);
    mcu_rd_n = 1'b1;
    mcu_cs_n = 1'b1;
    step(4);
  endtask
  task automatic pulse(input logic erase);
    if (erase) flash_erase_start = 1'b1;
    else flash_prog_start = 1'b1;
    step(1);
    flash_erase_start = 1'b0;
    flash_prog_start = 1'b0;
    step(2);
  endtask
  initial begin
    {sys_rst, mcu_cs_n, mcu_wr_n, mcu_rd_n} = 4'hF;
    {reset_pin_n, lockout_pin, pld_clock_input, power_down} = 4'h0;
    {flash_prog_start, flash_erase_start} = 2'b00;
    {mcu_addr, mcu_data_in, mc_d, pc_gp, gpio_out, mc_re, mc_pr} = {7{8'h00}};
    {io_oe_req, gpio_oe} = 16'hFFFF;
    ctl_pins = 5'h1F;
    step(3);
    sys_rst = 1'b0;
    step(POR + 4);
    check(io_oe | addr_oe | data_port_oe | periph_oe, 8'h00);
    check(sector_select_en, 8'h00);
    reset_pin_n = 1'b1;
    step(REC + 6);
    check(io_oe & addr_oe & data_port_oe & periph_oe, 8'hFF);
    check(8'(pld_out_valid & flash_ready), 8'h01);
    check(sector_select_en, 8'hFF);
    check(memory_map_config, 8'h1F & `RTP_VM_CLRMASK);
    rd(`RTP_OFF_PMA, 8'h00);
    rd(`RTP_OFF_PMB, 8'h00);
    rd(`RTP_OFF_TEST_EN, 8'h00);
    rd(`RTP_OFF_VM, 8'h1F & `RTP_VM_CLRMASK);
    rd(8'h55, 8'h00);
    check(mc_q, 8'h00);
    $display("Test power_on done");
    pld_clock_input = 1'b1;
    wr(`RTP_OFF_PMA, 8'h10);
    check(8'(pld_array_clk), 8'h00);
    wr(`RTP_OFF_PMA, 8'h20);
    check(8'(pld_array_clk), 8'h01);
    mc_d = 8'hA5;
    pld_clock_input = 1'b0;
    step(4);
    pld_clock_input = 1'b1;
    step(4);
    check(mc_q, 8'h00);
    wr(`RTP_OFF_PMA, 8'h00);
    pld_clock_input = 1'b0;
    step(4);
    pld_clock_input = 1'b1;
    step(4);
    check(mc_q, 8'hA5);
    mc_re = 8'h0F;
    step(2);
    check(mc_q, 8'hA0);
    {mc_re, mc_pr} = 16'h0003;
    step(2);
    check(mc_q, 8'hA3);
    mc_pr = 8'h00;
    for (i = 2; i < 7; i++) begin
      wr(`RTP_OFF_PMB, 8'h01 << i);
      check(8'(array_ctl), 8'h1F & ~(8'h01 << (i - 2)));
    end
    wr(`RTP_OFF_PMB, 8'h7C);
    power_down = 1'b1;
    step(4);
    check(8'(array_ctl), 8'h00);
    power_down = 1'b0;
    wr(`RTP_OFF_PMB, 8'h00);
    $display("Test gating done");
    check(pc_oe, 8'hFF);
    check(8'(test_pins_active), 8'h00);
    wr(`RTP_OFF_TEST_EN, 8'h01);
    check(8'(test_pins_active), 8'h01);
    check(pc_oe & 8'h63, 8'h00);
    ctl.send(`RTP_CMD_ENABLE);
    step(4);
    check(pc_oe & 8'h63, 8'h40);
    wr(`RTP_OFF_TEST_EN, 8'h00);
    check(8'(test_pins_active), 8'h01);
    ctl.unplug();
    step(4);
    check(8'(test_pins_active), 8'h00);
    check(pc_oe, 8'hFF);
    wr(`RTP_OFF_TEST_EN, 8'h01);
    wr(`RTP_OFF_PMA, 8'h10);
    $display("Test port done");
    reset_pin_n = 1'b0;
    step(WARM + 4);
    check(8'(pld_out_valid), 8'h01);
    check(io_oe, 8'h00);
    reset_pin_n = 1'b1;
    step(REC + 6);
    check(8'(test_pins_active), 8'h00);
    check(8'(pld_array_clk), 8'h00);
    check(mc_q, 8'hA3);
    rd(`RTP_OFF_PMA, 8'h10);
    rd(`RTP_OFF_VM, 8'h1F & `RTP_VM_CLRMASK);
    $display("Test warm_reset done");
    pulse(1'b0);
    check(8'(flash_ready), 8'h00);
    reset_pin_n = 1'b0;
    step(5);
    check(8'(flash_ready), 8'h01);
    reset_pin_n = 1'b1;
    step(REC + 6);
    lockout_pin = 1'b1;
    step(4);
    pulse(1'b1);
    check(8'(flash_ready), 8'h01);
    lockout_pin = 1'b0;
    step(4);
    pulse(1'b1);
    check(8'(flash_ready), 8'h00);
    step(`RTP_ERASE_CYC + 4);
    check(8'(flash_ready), 8'h01);
    $display("Test flash done");
    ctl.send(`RTP_CMD_ENABLE_EXT);
    step(4);
    check(pc_oe & 8'h58, 8'h58);
    check(pc_out & 8'h58, 8'h48);
    ctl.send(`RTP_CMD_ENABLE_OD);
    step(4);
    check(pc_oe & 8'h58, 8'h50);
    check(pc_out & 8'h58, 8'h08);
    ctl.send(`RTP_CMD_CLEAR);
    step(4);
    check(pc_oe & 8'h58, 8'h40);
    check(pc_out & 8'h58, 8'h58);
    ctl.send(`RTP_CMD_DISABLE);
    step(4);
    check(pc_oe & 8'h58, 8'h00);
    ctl.unplug();
    $display("Test extensions done");
    tally_and_finish();
  end
endmodule // rtp_top_test
`default_nettype wire
